// ===== ec_ctrl_pkg.sv
// package for the echo canceller detector and control block
package ec_ctrl_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h04;
   localparam logic [7:0] ADDR_CTRL3 = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_THRESH = 8'h10;
   localparam logic [7:0] ADDR_NOISE_CTRL = 8'h14;
   localparam logic [7:0] ADDR_NOISE_SCALE = 8'h18;
   localparam logic [7:0] ADDR_GAINS = 8'h1C;

   // control 1 fields
   localparam int C1_INJ_DIS = 0;
   localparam int C1_PAD12 = 1;
   localparam int C1_BYPASS = 2;
   localparam int C1_ADAPT_DIS = 3;
   // control 2 fields
   localparam int C2_SUPP_DIS = 0;
   localparam int C2_PHASE_DIS = 1;
   localparam int C2_AUTO_TONE = 2;
   localparam int C2_NB_DIS = 3;
   localparam int C2_OFFSET_DIS = 4;
   // control 3 fields
   localparam int C3_PATH_DET = 0;
   localparam int C3_PATH_CLR = 1;
   localparam int C3_SUPP_SEL = 2;
   localparam int C3_REJ_ECHO = 3;
   localparam int C3_REJ_DT = 4;
   localparam int C3_RAMP_SEL = 5;
   localparam int C3_RING_CLR = 6;
   // status fields
   localparam int ST_TONE = 0;
   localparam int ST_STATE_LO = 1;

   // reset values
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_CTRL2 = 8'h00;
   localparam logic [7:0] RST_CTRL3 = 8'h3C;
   localparam logic [15:0] RST_THRESH = 16'h4000;
   localparam logic [3:0] RST_RAMP_RATE = 4'h5;
   localparam logic [7:0] RST_NOISE_SCALE = 8'h16;
   localparam logic [11:0] RST_GAINS = 12'h000;

   // timing
   localparam int CLK_HZ = 20000000;
   localparam int FRAME_NS = 125000;
   localparam int FRAME_CYC = (FRAME_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int PLAIN_TONE_MS = 400;
   localparam int REV_TONE_MS = 1000;
   localparam int RELEASE_MS = 400;
   localparam int PLAIN_TONE_FR = PLAIN_TONE_MS * 8;
   localparam int REV_TONE_FR = REV_TONE_MS * 8;
   localparam int RELEASE_FR = RELEASE_MS * 8;
   localparam int SUPP_EXTRA_DB = 30;
   localparam int PAD_STEP_DB = 3;
   localparam int LEGACY_PAD_DB = 12;

   typedef enum logic [1:0] {
      ST_ENABLE,
      ST_DISABLE,
      ST_BYPASS
   } ec_state_t;

   // per-frame detector indications from the signal path
   typedef struct packed {
      logic tone_rx;
      logic tone_tx;
      logic reversal_rx;
      logic reversal_tx;
      logic quiet_rx;
      logic quiet_tx;
      logic path_change;
      logic narrow_band;
      logic ringing;
      logic below_thresh;
   } detect_t;

   // controls handed to the datapath
   typedef struct packed {
      logic adapt_en;
      logic clear_coef;
      logic pass_through;
      logic supp_on;
      logic noise_on;
      logic ring_suppress;
      logic offset_null_on;
      logic suppr_adv;
      logic ramp_scheme;
      logic rej_echo;
      logic rej_dt;
      logic [3:0] ramp_rate;
      logic [7:0] noise_scale;
      logic [15:0] thresh;
      logic [2:0] pad_rin;
      logic [2:0] pad_rout;
      logic [2:0] pad_sin;
      logic [2:0] pad_sout;
      logic path_det_on;
   } dp_ctrl_t;

endpackage

// ===== ec_detector_control.sv
// detector and control logic for one echo canceller channel
// What this block does
// - path-detect bit set enables major path change detection, fast reconverge
// - path-clear bit also set zeroes coefficients on major path change
// - threshold is 16-bit fraction times 32768, added to receive level in dB
// - residual below threshold gets 30 dB more loss plus comfort noise
// - suppressor-disable bit set turns the suppressor off
// - noise-injection-disable stops noise; both act only with suppressor on
// - suppressor-select 1 picks advanced, 0 picks original suppressor
// - advanced defaults: select 1, safeguards 1, scheme 1, rate 5, scale 16
// - scheme bit picks estimator; rate field direction depends on scheme
// - noise scaling value scales comfort noise level proportionally
// - safeguard bits at 0 disable echo and double-talk rejection
// - reversal mode: 2100 Hz tone one second with a reversal triggers
// - plain mode: 2100 Hz tone for 400 ms triggers
// - receive and send detectors; detection sets status, interrupt low
// - status holds until both inputs quiet 400 ms, then clears with interrupt
// - phase-check-disable 1 selects plain mode, else reversal mode
// - auto-tone bit lets detectors switch between adapt and bypass
// - ring-clear bit set detects and suppresses filter oscillation
// - narrow-band tones halt adaptation in any state unless disabled
// - offset null filters on both inputs, bypassed by disable bit
// - four ports scaled 0 to -12 dB in 3 dB steps from gains
// - legacy pad bit gives 12 dB receive loss overriding gains
// - bypass passes pcm, zeroes coefficients, held at least one frame
`timescale 1ns/10ps
module ec_detector_control (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic frame_i,
   input wire ec_ctrl_pkg::detect_t det_i,
   output ec_ctrl_pkg::dp_ctrl_t ctrl_o,
   output logic irq_n_o
);

   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] ctrl3_q;
   logic [15:0] thresh_q;
   logic [3:0] ramp_rate_q;
   logic [7:0] noise_scale_q;
   logic [11:0] gains_q;
   logic tone_q;
   logic irq_q;
   logic [13:0] tone_cnt_q [2];
   logic rev_seen_q [2];
   logic [13:0] quiet_cnt_q;
   logic [11:0] byp_cnt_q;
   logic auto_byp_q;
   logic clear_q;
   ec_ctrl_pkg::ec_state_t state_q;
   ec_ctrl_pkg::ec_state_t state_d;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic take;
   logic [1:0] trig;
   logic st_read;
   logic [31:0] rd_word;
   logic [31:0] rd_mask;
   logic [31:0] fwd_mask;
   wire logic [2:0] pad_lvl [4];

   assign take = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // bus address phase capture
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else if (clk_en_i && hready)
      begin
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         addr_q <= haddr[7:0];
      end
   end

   // register writes in data phase
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl1_q <= ec_ctrl_pkg::RST_CTRL1;
         ctrl2_q <= ec_ctrl_pkg::RST_CTRL2;
         ctrl3_q <= ec_ctrl_pkg::RST_CTRL3;
         thresh_q <= ec_ctrl_pkg::RST_THRESH;
         ramp_rate_q <= ec_ctrl_pkg::RST_RAMP_RATE;
         noise_scale_q <= ec_ctrl_pkg::RST_NOISE_SCALE;
         gains_q <= ec_ctrl_pkg::RST_GAINS;
      end
      else if (clk_en_i && wr_pend_q)
      begin
         case (addr_q)
            ec_ctrl_pkg::ADDR_CTRL1: ctrl1_q <= hwdata[7:0];
            ec_ctrl_pkg::ADDR_CTRL2: ctrl2_q <= hwdata[7:0];
            ec_ctrl_pkg::ADDR_CTRL3: ctrl3_q <= hwdata[7:0];
            ec_ctrl_pkg::ADDR_THRESH: thresh_q <= hwdata[15:0];
            ec_ctrl_pkg::ADDR_NOISE_CTRL: ramp_rate_q <= hwdata[3:0];
            ec_ctrl_pkg::ADDR_NOISE_SCALE: noise_scale_q <= hwdata[7:0];
            ec_ctrl_pkg::ADDR_GAINS: gains_q <= hwdata[11:0];
            default: ;
         endcase
      end
   end

   // read word for the address now on the bus
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (haddr[7:0])
         ec_ctrl_pkg::ADDR_CTRL1: rd_word = {24'h000000, ctrl1_q};
         ec_ctrl_pkg::ADDR_CTRL2: rd_word = {24'h000000, ctrl2_q};
         ec_ctrl_pkg::ADDR_CTRL3: rd_word = {24'h000000, ctrl3_q};
         ec_ctrl_pkg::ADDR_STATUS:
            rd_word = {29'h00000000, state_q, tone_q};
         ec_ctrl_pkg::ADDR_THRESH: rd_word = {16'h0000, thresh_q};
         ec_ctrl_pkg::ADDR_NOISE_CTRL:
            rd_word = {28'h0000000, ramp_rate_q};
         ec_ctrl_pkg::ADDR_NOISE_SCALE:
            rd_word = {24'h000000, noise_scale_q};
         ec_ctrl_pkg::ADDR_GAINS: rd_word = {20'h00000, gains_q};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // writable bits per address; status is read-only, never forwarded
   always_comb
   begin
      rd_mask = 32'h0000_0000;
      case (haddr[7:0])
         ec_ctrl_pkg::ADDR_CTRL1: rd_mask = 32'h0000_00FF;
         ec_ctrl_pkg::ADDR_CTRL2: rd_mask = 32'h0000_00FF;
         ec_ctrl_pkg::ADDR_CTRL3: rd_mask = 32'h0000_00FF;
         ec_ctrl_pkg::ADDR_THRESH: rd_mask = 32'h0000_FFFF;
         ec_ctrl_pkg::ADDR_NOISE_CTRL: rd_mask = 32'h0000_000F;
         ec_ctrl_pkg::ADDR_NOISE_SCALE: rd_mask = 32'h0000_00FF;
         ec_ctrl_pkg::ADDR_GAINS: rd_mask = 32'h0000_0FFF;
         default: rd_mask = 32'h0000_0000;
      endcase
   end

   // a write still in its data phase to the address being read is
   // forwarded, else a pipelined read right behind it sees stale data
   assign fwd_mask = (wr_pend_q && (addr_q == haddr[7:0])) ? rd_mask :
      32'h0000_0000;

   // read data registered at the address-to-data boundary
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         hrdata <= 32'h0000_0000;
      else if (clk_en_i && hready)
      begin
         if (take && !hwrite)
            hrdata <= (rd_word & ~fwd_mask) | (hwdata & fwd_mask);
         else
            hrdata <= 32'h0000_0000;
      end
   end

   assign st_read = rd_pend_q && (addr_q == ec_ctrl_pkg::ADDR_STATUS);

   // per-input tone qualification, receive and send
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_tone
         logic present;
         logic rev;
         assign present = (i == 0) ? det_i.tone_rx : det_i.tone_tx;
         assign rev = (i == 0) ? det_i.reversal_rx : det_i.reversal_tx;
         always_ff @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               tone_cnt_q[i] <= 14'h0000;
               rev_seen_q[i] <= 1'b0;
            end
            else if (clk_en_i && frame_i)
            begin
               if (!present)
               begin
                  tone_cnt_q[i] <= 14'h0000;
                  rev_seen_q[i] <= 1'b0;
               end
               else
               begin
                  if (tone_cnt_q[i] != 14'h3FFF)
                     tone_cnt_q[i] <= tone_cnt_q[i] + 14'h0001;
                  if (rev)
                     rev_seen_q[i] <= 1'b1;
               end
            end
         end
         // plain mode ignores reversals, reversal mode needs one
         assign trig[i] = ctrl2_q[ec_ctrl_pkg::C2_PHASE_DIS] ?
            (tone_cnt_q[i] >= 14'(ec_ctrl_pkg::PLAIN_TONE_FR)) :
            ((tone_cnt_q[i] >= 14'(ec_ctrl_pkg::REV_TONE_FR)) &&
             rev_seen_q[i]);
      end
   endgenerate

   // latched status with release after sustained quiet on both inputs
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tone_q <= 1'b0;
         quiet_cnt_q <= 14'h0000;
      end
      else if (clk_en_i && frame_i)
      begin
         if (!tone_q)
         begin
            quiet_cnt_q <= 14'h0000;
            if (|trig)
               tone_q <= 1'b1;
         end
         else if (det_i.quiet_rx && det_i.quiet_tx)
         begin
            if (quiet_cnt_q >= 14'(ec_ctrl_pkg::RELEASE_FR - 1))
            begin
               tone_q <= 1'b0;
               quiet_cnt_q <= 14'h0000;
            end
            else
               quiet_cnt_q <= quiet_cnt_q + 14'h0001;
         end
         else
            quiet_cnt_q <= 14'h0000;
      end
   end

   // interrupt on every status edge; a new edge wins over the read clear
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         irq_q <= 1'b0;
      else if (clk_en_i)
      begin
         if (frame_i && !tone_q && (|trig))
            irq_q <= 1'b1;
         else if (frame_i && tone_q && det_i.quiet_rx && det_i.quiet_tx &&
                  quiet_cnt_q >= 14'(ec_ctrl_pkg::RELEASE_FR - 1))
            irq_q <= 1'b1;
         else if (st_read)
            irq_q <= 1'b0;
      end
   end
   assign irq_n_o = !irq_q;

   // automatic bypass follows status when enabled
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         auto_byp_q <= 1'b0;
      else if (clk_en_i)
         auto_byp_q <= ctrl2_q[ec_ctrl_pkg::C2_AUTO_TONE] && tone_q;
   end

   always_comb
   begin
      if (ctrl1_q[ec_ctrl_pkg::C1_BYPASS] || auto_byp_q)
         state_d = ec_ctrl_pkg::ST_BYPASS;
      else if (ctrl1_q[ec_ctrl_pkg::C1_ADAPT_DIS])
         state_d = ec_ctrl_pkg::ST_DISABLE;
      else
         state_d = ec_ctrl_pkg::ST_ENABLE;
   end

   // bypass is held for at least one frame once entered
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= ec_ctrl_pkg::ST_ENABLE;
         byp_cnt_q <= 12'h000;
      end
      else if (clk_en_i)
      begin
         case (state_q)
            ec_ctrl_pkg::ST_BYPASS:
            begin
               if (byp_cnt_q != 12'h000)
                  byp_cnt_q <= byp_cnt_q - 12'h001;
               else
                  state_q <= state_d;
            end
            ec_ctrl_pkg::ST_ENABLE, ec_ctrl_pkg::ST_DISABLE:
            begin
               state_q <= state_d;
               if (state_d == ec_ctrl_pkg::ST_BYPASS)
                  byp_cnt_q <= 12'(ec_ctrl_pkg::FRAME_CYC - 1);
            end
            default: state_q <= ec_ctrl_pkg::ST_ENABLE;
         endcase
      end
   end

   // registered clear, one clock after a detected major path change, for as long as it lasts
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         clear_q <= 1'b0;
      else if (clk_en_i)
         clear_q <= det_i.path_change &&
            ctrl3_q[ec_ctrl_pkg::C3_PATH_DET] &&
            ctrl3_q[ec_ctrl_pkg::C3_PATH_CLR];
   end

   // datapath controls
   logic supp_on;
   logic [2:0] pad_rin;
   assign supp_on = !ctrl2_q[ec_ctrl_pkg::C2_SUPP_DIS];
   // per-port pad clamp; codes above four steps saturate at -12 dB
   generate
      for (genvar p = 0; p < 4; p++)
      begin : g_pad
         logic [2:0] code;
         assign code = gains_q[3 * p +: 3];
         assign pad_lvl[p] = (code > 3'd4) ? 3'd4 : code;
      end
   endgenerate

   // legacy pad is four 3 dB steps and overrides the gains field
   assign pad_rin = ctrl1_q[ec_ctrl_pkg::C1_PAD12] ? 3'd4 : pad_lvl[0];

   always_comb
   begin
      ctrl_o = '0;
      ctrl_o.pass_through = (state_q == ec_ctrl_pkg::ST_BYPASS);
      ctrl_o.clear_coef = ctrl_o.pass_through || clear_q;
      // narrow-band halt applies in every state
      ctrl_o.adapt_en = (state_q == ec_ctrl_pkg::ST_ENABLE) &&
         !(det_i.narrow_band && !ctrl2_q[ec_ctrl_pkg::C2_NB_DIS]);
      ctrl_o.path_det_on = ctrl3_q[ec_ctrl_pkg::C3_PATH_DET];
      ctrl_o.supp_on = supp_on && det_i.below_thresh;
      ctrl_o.noise_on = supp_on && det_i.below_thresh &&
         !ctrl1_q[ec_ctrl_pkg::C1_INJ_DIS];
      ctrl_o.thresh = supp_on ? thresh_q : 16'h0000;
      ctrl_o.suppr_adv = ctrl3_q[ec_ctrl_pkg::C3_SUPP_SEL];
      ctrl_o.ramp_scheme = ctrl3_q[ec_ctrl_pkg::C3_RAMP_SEL];
      ctrl_o.ramp_rate = ramp_rate_q;
      ctrl_o.noise_scale = noise_scale_q;
      ctrl_o.rej_echo = ctrl3_q[ec_ctrl_pkg::C3_REJ_ECHO];
      ctrl_o.rej_dt = ctrl3_q[ec_ctrl_pkg::C3_REJ_DT];
      ctrl_o.ring_suppress = ctrl3_q[ec_ctrl_pkg::C3_RING_CLR] &&
         det_i.ringing;
      ctrl_o.offset_null_on = !ctrl2_q[ec_ctrl_pkg::C2_OFFSET_DIS];
      ctrl_o.pad_rin = pad_rin;
      ctrl_o.pad_rout = pad_lvl[1];
      ctrl_o.pad_sin = pad_lvl[2];
      ctrl_o.pad_sout = pad_lvl[3];
   end

endmodule

// ===== ec_detector_control_chk.sv
// assertion checker for the detector and control block
`timescale 1ns/10ps
module ec_detector_control_chk (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic frame_i,
   input wire ec_ctrl_pkg::detect_t det_i,
   input wire ec_ctrl_pkg::dp_ctrl_t ctrl_o,
   input wire logic irq_n_o
);
   localparam int HOLD = ec_ctrl_pkg::FRAME_CYC;
   int byp_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // cycles spent in bypass, so that a short stay shows at the exit
   always_ff @(posedge clk_i or posedge reset_i)
      if (reset_i)
         byp_q <= 0;
      else
         byp_q <= ctrl_o.pass_through ? byp_q + 1 : 0;
   sequence rd_thresh;
      hsel && hready && htrans[1] && !hwrite && clk_en_i &&
         haddr == {24'h00, ec_ctrl_pkg::ADDR_THRESH};
   endsequence
   sequence left_reset;
      $fell(reset_i);
   endsequence
   sequence path_clear;
      ctrl_o.clear_coef && !ctrl_o.pass_through;
   endsequence
   thresh_read_a: assert property (
      rd_thresh ##1 ctrl_o.thresh != 16'h0000 |->
         hrdata == {16'h0000, ctrl_o.thresh})
      else $error("threshold readback differs from control output");
   suppr_defaults_a: assert property (
      left_reset |-> ctrl_o.suppr_adv && ctrl_o.rej_echo && ctrl_o.rej_dt &&
         ctrl_o.ramp_scheme && ctrl_o.ramp_rate == 4'h5 &&
         ctrl_o.noise_scale == 8'h16)
      else $error("suppressor defaults wrong after reset");
   path_cause_a: assert property (
      path_clear |-> $past(det_i.path_change) && $past(ctrl_o.path_det_on))
      else $error("coefficient clear without path change");
   noise_gate_a: assert property (
      !ctrl_o.supp_on |-> !ctrl_o.noise_on)
      else $error("comfort noise on with suppressor off");
   bypass_clear_a: assert property (
      ctrl_o.pass_through |-> !ctrl_o.adapt_en && ctrl_o.clear_coef)
      else $error("bypass without coefficient clear");
   bypass_hold_a: assert property (
      $fell(ctrl_o.pass_through) |-> byp_q >= HOLD)
      else $error("bypass left before one frame");
   irq_frame_a: assert property (
      $fell(irq_n_o) |-> $past(frame_i) || $past(frame_i, 2))
      else $error("interrupt raised away from a frame strobe");
   pad_range_a: assert property (
      ctrl_o.pad_rin <= 3'h4 && ctrl_o.pad_rout <= 3'h4 &&
         ctrl_o.pad_sin <= 3'h4 && ctrl_o.pad_sout <= 3'h4)
      else $error("level pad beyond twelve decibels");
endmodule
bind ec_detector_control ec_detector_control_chk u_chk (.clk_i, .reset_i,
   .clk_en_i, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .frame_i,
   .det_i, .ctrl_o, .irq_n_o);

// ===== ec_sig_path_model.sv
// signal path stand-in: frame strobe and detector levels
`timescale 1ns/10ps
module ec_sig_path_model #(
   parameter int FRAME_DIV = 2,
   parameter int REV_FR = 3600
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire ec_ctrl_pkg::detect_t want_i,
   output logic frame_o,
   output ec_ctrl_pkg::detect_t det_o
);
   int div_q;
   int fr_q;
   ec_ctrl_pkg::detect_t lvl_q;
   // frames far faster than 8 kHz so that tone counts stay short
   always_ff @(posedge clk_i or posedge reset_i)
      if (reset_i)
      begin
         div_q <= 0;
         fr_q <= 0;
         frame_o <= 1'b0;
         lvl_q <= '0;
      end
      else
      begin
         div_q <= (div_q == FRAME_DIV - 1) ? 0 : div_q + 1;
         frame_o <= (div_q == 0);
         if (div_q == 0)
         begin
            fr_q <= fr_q + 1;
            lvl_q <= want_i;
            lvl_q.reversal_rx <= want_i.tone_rx && fr_q % REV_FR == 0;
            lvl_q.reversal_tx <= want_i.tone_tx && fr_q % REV_FR == 0;
         end
      end
   // per-frame levels mean nothing away from the strobe
   always_comb
   begin
      det_o = frame_o ? lvl_q : ~lvl_q;
      det_o.path_change = want_i.path_change;
      det_o.narrow_band = want_i.narrow_band;
      det_o.ringing = want_i.ringing;
      det_o.below_thresh = want_i.below_thresh;
   end
endmodule

// ===== ec_detector_control_tb.sv
// self-checking bench for the detector and control block
`timescale 1ns/10ps
module ec_detector_control_tb;
   localparam logic [31:0] MASK [8] = '{32'hFF, 32'hFF, 32'hFF, 32'h7,
      32'hFFFF, 32'hF, 32'hFF, 32'hFFF};
   logic clk_i;
   logic reset_i;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic frame_i;
   logic irq_n_o;
   ec_ctrl_pkg::detect_t det_i;
   ec_ctrl_pkg::dp_ctrl_t ctrl_o;
   ec_ctrl_pkg::detect_t want;
   logic [31:0] mdl [8];
   logic [31:0] rd;
   logic [31:0] keep;
   logic clk_en;
   logic [15:0] lfsr_q;
   int fails;
   int checks;
   ec_detector_control u_ec_detector_control (.clk_i, .reset_i,
      .clk_en_i(clk_en), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .frame_i,
      .det_i, .ctrl_o, .irq_n_o);
   ec_sig_path_model u_ec_sig_path_model (.clk_i, .reset_i, .want_i(want),
      .frame_o(frame_i), .det_o(det_i));
   always #25 clk_i = ~clk_i;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [2:0] pad(input logic [2:0] v);
      return v > 3'h4 ? 3'h4 : v;
   endfunction
   task automatic summarize;
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: read %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: port %h, want %h", $time, got, exp);
      end
   endtask
   // value taken before the edge equals the value at the edge, race free
   task automatic wt(output logic [31:0] d);
      logic r;
      do
      begin
         @(negedge clk_i);
         r = hreadyout;
         d = hrdata;
         @(posedge clk_i);
      end
      while (r !== 1'b1);
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00, a};
      hwrite <= wr;
      wt(d);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wt(d);
      if (wr && a < 8'h20 && a != ec_ctrl_pkg::ADDR_STATUS)
         mdl[a[4:2]] = wd & MASK[a[4:2]];
   endtask
   task automatic rd_chk(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, rd);
      chk_bus(rd, a < 8'h20 ? mdl[a[4:2]] : 32'h0);
   endtask
   task automatic st(input logic [31:0] v);
      mdl[3] = v;
      rd_chk(ec_ctrl_pkg::ADDR_STATUS);
   endtask
   task automatic fr(input int n);
      repeat (n) @(posedge frame_i);
   endtask
   task automatic irq_is(input logic v);
      @(negedge clk_i);
      chk_sig(irq_n_o, v);
      @(posedge clk_i);
   endtask
   task automatic chk_ctl;
      @(negedge clk_i);
      chk_sig(ctrl_o.thresh, mdl[1][0] ? 32'h0 : mdl[4]);
      chk_sig(ctrl_o.noise_scale, mdl[6]);
      chk_sig(ctrl_o.ramp_rate, mdl[5]);
      chk_sig({ctrl_o.ramp_scheme, ctrl_o.rej_dt, ctrl_o.rej_echo,
         ctrl_o.suppr_adv}, mdl[2][5:2]);
      chk_sig({ctrl_o.ring_suppress, ctrl_o.path_det_on},
         {mdl[2][6] & want.ringing, mdl[2][0]});
      chk_sig({ctrl_o.supp_on, ctrl_o.noise_on, ctrl_o.offset_null_on},
         {~mdl[1][0] & want.below_thresh,
         ~mdl[1][0] & ~mdl[0][0] & want.below_thresh,
         ~mdl[1][4]});
      chk_sig({ctrl_o.pad_sout, ctrl_o.pad_sin, ctrl_o.pad_rout,
         ctrl_o.pad_rin}, {pad(mdl[7][11:9]), pad(mdl[7][8:6]),
         pad(mdl[7][5:3]), mdl[0][1] ? 3'h4 : pad(mdl[7][2:0])});
      @(posedge clk_i);
   endtask
   initial
   begin
      repeat (80000) @(posedge clk_i);
      fails++;
      summarize();
   end
   initial
   begin
      clk_i = 1'b0;
      reset_i = 1'b1;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      want = '0;
      fails = 0;
      checks = 0;
      lfsr_q = 16'h003A;
      mdl = '{32'h0, 32'h0, 32'h3C, 32'h0, 32'h4000, 32'h5, 32'h16, 32'h0};
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 9; i++)
         rd_chk(8'(i * 4));
      chk_ctl();
      repeat (3)
      begin
         for (int i = 0; i < 9; i++)
         begin
            lfsr_q = lfsr(lfsr_q);
            want.ringing <= lfsr_q[0];
            want.below_thresh <= lfsr_q[1];
            if (i != 3)
               xfer(1'b1, 8'(i * 4), {~lfsr_q, lfsr_q}, rd);
         end
         for (int i = 0; i < 9; i++)
            if (i != 3)
               rd_chk(8'(i * 4));
         chk_ctl();
      end
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL1, 32'h0, rd);
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL2, 32'h0, rd);
      // random control words may have left the channel in bypass
      repeat (2600) @(posedge clk_i);
      for (int i = 0; i < 2; i++)
      begin
         xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL3, 32'h3D | 32'(i << 1), rd);
         want.path_change <= 1'b1;
         @(posedge clk_i);
         want.path_change <= 1'b0;
         @(negedge clk_i);
         chk_sig(ctrl_o.clear_coef, i);
         @(posedge clk_i);
      end
      want.narrow_band <= 1'b1;
      @(negedge clk_i);
      chk_sig(ctrl_o.adapt_en, 1'b0);
      @(posedge clk_i);
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL2, 32'h8, rd);
      @(negedge clk_i);
      chk_sig(ctrl_o.adapt_en, 1'b1);
      @(posedge clk_i);
      want.narrow_band <= 1'b0;
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL2, 32'h2, rd);
      want.tone_rx <= 1'b1;
      fr(3195);
      st(32'h0);
      fr(10);
      irq_is(1'b0);
      st(32'h1);
      irq_is(1'b1);
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL1, 32'h4, rd);
      want.tone_rx <= 1'b0;
      want.quiet_rx <= 1'b1;
      fr(3300);
      st(32'h5);
      want.quiet_tx <= 1'b1;
      fr(3195);
      st(32'h5);
      fr(10);
      irq_is(1'b0);
      st(32'h4);
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL1, 32'h0, rd);
      xfer(1'b1, ec_ctrl_pkg::ADDR_CTRL2, 32'h4, rd);
      want.quiet_rx <= 1'b0;
      want.quiet_tx <= 1'b0;
      want.tone_tx <= 1'b1;
      fr(7995);
      st(32'h0);
      fr(10);
      irq_is(1'b0);
      st(32'h5);
      want.tone_tx <= 1'b0;
      want.quiet_rx <= 1'b1;
      want.quiet_tx <= 1'b1;
      fr(3210);
      st(32'h0);
      // a write while the clock enable is low must not land
      keep = mdl[7];
      clk_en <= 1'b0;
      xfer(1'b1, ec_ctrl_pkg::ADDR_GAINS, 32'h0000_0FFF, rd);
      clk_en <= 1'b1;
      mdl[7] = keep;
      rd_chk(ec_ctrl_pkg::ADDR_GAINS);
      summarize();
   end
endmodule
